// File: shared/acsc_pkg.sv
/*
 Constants, encodings and timing counts shared by the conversion control
 block and its link-side serial shifter.
 Assumes a 250 MHz system clock; the cycle counts below are derived from it.
*/
package acsc_pkg;

	// Result word.
	localparam int WORD_BITS = 16;
	localparam int WORD_MSB = WORD_BITS - 1;
	localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
	localparam logic [4:0] BIT_COUNT_NONE = 5'h00;
	localparam logic [4:0] BIT_COUNT_LAST = 5'h01;

	// Straight binary to two's complement is a flip of the top bit.
	localparam logic [15:0] FORMAT_FLIP = 16'h8000;
	localparam logic [15:0] FORMAT_KEEP = 16'h0000;

	// Clock rate.
	localparam int SYS_CLK_PERIOD_NS = 4;

	// Least time that both start lines must stay low together.
	localparam int START_HOLD_NS = 50;
	localparam int START_HOLD_CYCLES =
		(START_HOLD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam logic [3:0] START_HOLD_LAST = 4'(START_HOLD_CYCLES - 1);
	localparam logic [3:0] START_HOLD_ZERO = 4'h0;
	localparam logic [3:0] START_HOLD_STEP = 4'h1;

	// Quarter of one internal data clock period (longest, rounds down).
	localparam int BIT_QUARTER_NS = 16;
	localparam int BIT_QUARTER_CYCLES =
		(BIT_QUARTER_NS / SYS_CLK_PERIOD_NS < 1) ? 1 :
		BIT_QUARTER_NS / SYS_CLK_PERIOD_NS;
	localparam logic [2:0] QUARTER_LAST = 3'(BIT_QUARTER_CYCLES - 1);
	localparam logic [2:0] QUARTER_ZERO = 3'h0;
	localparam logic [2:0] QUARTER_STEP = 3'h1;

	// Bit phases: data changes in phase 0, clock high in phases 1 and 2.
	localparam logic [1:0] PHASE_SETUP = 2'h0;
	localparam logic [1:0] PHASE_RISE = 2'h1;
	localparam logic [1:0] PHASE_HIGH = 2'h2;
	localparam logic [1:0] PHASE_HOLD = 2'h3;
	localparam logic [1:0] PHASE_STEP = 2'h1;

	// Pin synchroniser lanes and their idle levels after reset.
	localparam int PIN_COUNT = 6;
	localparam int PIN_CS = 0;
	localparam int PIN_RC = 1;
	localparam int PIN_PD = 2;
	localparam int PIN_CLKSEL = 3;
	localparam int PIN_FMT = 4;
	localparam int PIN_CHAIN = 5;
	localparam logic [5:0] PIN_RESET = 6'h03;

	// Conversion control states.
	typedef enum logic [2:0] {
		CTRL_TRACK = 3'b001,
		CTRL_QUALIFY = 3'b010,
		CTRL_CONVERT = 3'b100
	} acsc_ctrl_state_t;

endpackage : acsc_pkg

// File: logic/acsc_link_shift.sv
/*
 Link-side serial shifter clocked by the externally supplied data clock.
 Assumes the word and chain level are held stable by the system domain
 from before the load toggle changes until the next toggle.
*/
`timescale 1ns/10ps
module acsc_link_shift (
	// Link clock and system reset
	input wire logic link_clk,
	input wire logic sys_rst,
	// Load request from the system domain
	input wire logic load_toggle,
	input wire logic [15:0] word,
	input wire logic chain_level,
	// Serial output
	output logic data
);

	logic rst_meta;
	logic rst_sync;
	logic tgl_meta;
	logic tgl_sync;
	logic tgl_seen;
	logic [15:0] shift;
	logic [4:0] left;
	logic tag_level;

	wire load = tgl_sync ^ tgl_seen;
	wire running = left != acsc_pkg::BIT_COUNT_NONE;
	wire last = left == acsc_pkg::BIT_COUNT_LAST;

	// The reset is re-timed so that the link logic leaves it cleanly.
	always_ff @(posedge link_clk) begin
		rst_meta <= sys_rst;
		rst_sync <= rst_meta;
	end

	always_ff @(posedge link_clk) begin
		if (rst_sync) begin
			tgl_meta <= 1'b0;
			tgl_sync <= 1'b0;
			tgl_seen <= 1'b0;
		end else begin
			tgl_meta <= load_toggle;
			tgl_sync <= tgl_meta;
			tgl_seen <= tgl_sync;
		end
	end

	// Word is sampled only after the toggle has crossed, so it is quiet.
	always_ff @(posedge link_clk) begin
		if (rst_sync) begin
			left <= acsc_pkg::BIT_COUNT_NONE;
			shift <= acsc_pkg::FORMAT_KEEP;
			tag_level <= 1'b0;
			data <= 1'b0;
		end else if (load) begin
			left <= acsc_pkg::BIT_COUNT_FULL;
			shift <= word;
			tag_level <= chain_level;
			data <= word[acsc_pkg::WORD_MSB];
		end else if (running) begin
			left <= 5'(left - acsc_pkg::BIT_COUNT_LAST);
			shift <= {shift[acsc_pkg::WORD_MSB - 1:0], 1'b0};
			data <= last ? tag_level : shift[acsc_pkg::WORD_MSB - 1]; // RL16
		end
	end

endmodule : acsc_link_shift

// File: logic/acsc_ctrl.sv
/*
 Conversion control and serial result output of a 16-bit successive
 approximation converter: start qualification, busy, power-down, result
 formatting, internal data clock generation and the link-side shifter.
 Assumes an analog core that holds the input on CORE_HOLD and reports the
 finished straight-binary code with a one-cycle CORE_DONE, both on SYS_CLK.
 All host pins are asynchronous and are synchronised here.
*/
`timescale 1ns/10ps

// Functional notes
// RL1 - Read/convert low: chip select fall starts conversion.
// RL2 - Read/convert high: chip select fall starts readout.
// RL3 - Busy low from start until result loaded.
// RL4 - Power-down high refuses conversion starts.
// RL5 - Power-down keeps last result intact.
// RL6 - Host holds both lines low 50 ns.
// RL7 - Start independent of which line falls first.
// RL8 - Host spaces the two falling edges 10 ns.
// RL9 - Completion raises busy, resumes tracking.
// RL10 - Chip select tied low: read/convert decides.
// RL11 - First output after power-up is undefined.
// RL12 - Clock select low: internal clock, high: external.
// RL13 - Internal mode: previous result, 16 bits, MSB first.
// RL14 - Internal mode: exactly 16 clock pulses.
// RL15 - Each bit stable across both clock edges.
// RL16 - After LSB, data shows captured chain level.
// RL17 - After sixteenth bit, clock stays low.
// RL18 - Format low: two's complement; high: straight binary.
// RL19 - Chip select low: read/convert rise enables readout.
// RL20 - Starts while busy are ignored.
module acsc_ctrl (
	// System clock and reset
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	// Host control pins
	input wire logic CS_N,
	input wire logic READ_CONVERT,
	input wire logic POWER_DOWN_IN,
	input wire logic CLOCK_SOURCE_SELECT,
	input wire logic RESULT_FORMAT_SELECT,
	input wire logic CHAIN_IN,
	output logic BUSY_N,
	// Serial link pins
	input wire logic SERIAL_BIT_CLOCK_IN,
	output logic SERIAL_BIT_CLOCK_OUT,
	output logic SERIAL_BIT_CLOCK_OE,
	output logic SERIAL_DATA,
	// Analog core
	output logic CORE_HOLD,
	input wire logic CORE_DONE,
	input wire logic [15:0] CORE_CODE,
	// Status
	output logic POWER_SAVE,
	output logic TRACKING
);

	// Edge of a synchronised level towards the given level.
	function automatic logic edge_to(
		input logic prev,
		input logic now,
		input logic level
	);
		edge_to = (prev != level) && (now == level);
	endfunction : edge_to

	logic [5:0] pin_raw;
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;
	logic [5:0] pin_prev;

	acsc_pkg::acsc_ctrl_state_t state;
	acsc_pkg::acsc_ctrl_state_t next_state;
	logic [3:0] hold_cnt;
	logic [3:0] next_hold_cnt;
	logic busy_n;
	logic core_hold;
	logic [15:0] result_word;
	logic tag_level;
	logic read_toggle;
	logic [15:0] read_word;
	logic read_tag;

	logic [4:0] ser_left;
	logic [4:0] next_ser_left;
	logic [1:0] ser_phase;
	logic [1:0] next_ser_phase;
	logic [2:0] ser_quarter;
	logic [2:0] next_ser_quarter;
	logic [15:0] ser_shift;
	logic [15:0] next_ser_shift;
	logic int_data;
	logic next_int_data;
	logic int_clk;
	logic next_int_clk;
	logic link_data;

	assign pin_raw = {
		CHAIN_IN,
		RESULT_FORMAT_SELECT,
		CLOCK_SOURCE_SELECT,
		POWER_DOWN_IN,
		READ_CONVERT,
		CS_N
	};

	// Every host pin passes two flip-flops before any logic reads it.
	// The first stage feeds the second stage only.
	// Lanes reset to the idle pin levels, so that no false edge follows
	// the end of reset.
	generate
		for (genvar i = 0; i < acsc_pkg::PIN_COUNT; i++) begin : g_sync
			always_ff @(posedge SYS_CLK) begin
				if (SYS_RST) begin
					pin_meta[i] <= acsc_pkg::PIN_RESET[i];
					pin_sync[i] <= acsc_pkg::PIN_RESET[i];
					pin_prev[i] <= acsc_pkg::PIN_RESET[i];
				end else begin
					pin_meta[i] <= pin_raw[i]; // RL8
					pin_sync[i] <= pin_meta[i];
					pin_prev[i] <= pin_sync[i];
				end
			end
		end
	endgenerate

	wire cs_n = pin_sync[acsc_pkg::PIN_CS];
	wire rc = pin_sync[acsc_pkg::PIN_RC];
	wire power_down = pin_sync[acsc_pkg::PIN_PD];
	wire clk_ext = pin_sync[acsc_pkg::PIN_CLKSEL];
	wire fmt_binary = pin_sync[acsc_pkg::PIN_FMT];
	wire chain = pin_sync[acsc_pkg::PIN_CHAIN];
	wire cs_prev = pin_prev[acsc_pkg::PIN_CS];
	wire rc_prev = pin_prev[acsc_pkg::PIN_RC];

	// Both lines are OR'd, so the later of the two falls starts the hold.
	// With chip select tied low the read/convert line alone does it.
	wire start_line = cs_n | rc; // RL7
	wire start_prev = cs_prev | rc_prev;
	wire start_fell = edge_to(start_prev, start_line, 1'b0); // RL1 RL10

	// Read requests: chip select falls with read/convert high, or
	// read/convert rises with chip select low.
	wire read_by_cs = edge_to(cs_prev, cs_n, 1'b0) & rc; // RL2
	wire read_by_rc = edge_to(rc_prev, rc, 1'b1) & ~cs_n; // RL19 RL10
	wire read_req = (read_by_cs | read_by_rc) & clk_ext;

	// Conversion control.
	wire in_track = state == acsc_pkg::CTRL_TRACK;
	wire in_qualify = state == acsc_pkg::CTRL_QUALIFY;
	wire in_convert = state == acsc_pkg::CTRL_CONVERT;
	wire hold_done = hold_cnt == acsc_pkg::START_HOLD_LAST;

	// Qualify drops an attempt as soon as either line rises or power-down
	// comes on; the host must then lower the lines again.
	// A request that arrives while converting is simply not looked at.
	wire arm = in_track & start_fell & ~power_down; // RL4 RL20
	wire qual_drop = in_qualify & (power_down | start_line); // RL4
	wire conv_start = in_qualify & ~power_down & ~start_line
		& hold_done; // RL6
	wire conv_done = in_convert & CORE_DONE;

	// Track keeps the hold counter at zero, so every attempt counts the
	// full hold time afresh.
	always_comb begin
		next_state = state;
		next_hold_cnt = hold_cnt;
		unique case (state)
			acsc_pkg::CTRL_TRACK: begin
				next_hold_cnt = acsc_pkg::START_HOLD_ZERO;
				if (arm) begin
					next_state = acsc_pkg::CTRL_QUALIFY;
				end
			end
			acsc_pkg::CTRL_QUALIFY: begin
				if (qual_drop) begin
					next_state = acsc_pkg::CTRL_TRACK;
				end else if (conv_start) begin
					next_state = acsc_pkg::CTRL_CONVERT; // RL1
				end else begin
					next_hold_cnt = 4'(hold_cnt + acsc_pkg::START_HOLD_STEP);
				end
			end
			acsc_pkg::CTRL_CONVERT: begin
				if (conv_done) begin
					next_state = acsc_pkg::CTRL_TRACK; // RL9
				end
			end
			default: begin
				next_state = acsc_pkg::CTRL_TRACK;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			state <= acsc_pkg::CTRL_TRACK;
			hold_cnt <= acsc_pkg::START_HOLD_ZERO;
		end else begin
			state <= next_state;
			hold_cnt <= next_hold_cnt;
		end
	end

	// Busy falls with the start and rises on the edge that loads the word.
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			busy_n <= 1'b1;
			core_hold <= 1'b0;
		end else begin
			busy_n <= conv_start ? 1'b0 : conv_done ? 1'b1 : busy_n; // RL3 RL9
			core_hold <= conv_start;
		end
	end

	// Result word is deliberately left out of reset: after power-up it
	// holds no real conversion, and nothing pretends otherwise.
	wire [15:0] fmt_mask = fmt_binary ? acsc_pkg::FORMAT_KEEP :
		acsc_pkg::FORMAT_FLIP;
	always_ff @(posedge SYS_CLK) begin
		if (conv_done) begin
			result_word <= CORE_CODE ^ fmt_mask; // RL18 RL3 RL11 RL5
		end
	end
	// Power-down only blocks new starts, so the word above stays put. RL5

	// Chain level is caught at the start of each conversion.
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			tag_level <= 1'b0;
		end else if (conv_start) begin
			tag_level <= chain; // RL16
		end
	end

	// Internal data clock: a divider on SYS_CLK, four quarters per bit.
	// Data moves only in the low setup quarter, well away from both edges.
	wire launch = conv_start & ~clk_ext; // RL12 RL13
	wire running = ser_left != acsc_pkg::BIT_COUNT_NONE;
	wire quarter_end = ser_quarter == acsc_pkg::QUARTER_LAST;
	wire bit_end = running & quarter_end
		& (ser_phase == acsc_pkg::PHASE_HOLD);
	wire last_bit = ser_left == acsc_pkg::BIT_COUNT_LAST;

	assign next_ser_left = launch ? acsc_pkg::BIT_COUNT_FULL :
		bit_end ? 5'(ser_left - acsc_pkg::BIT_COUNT_LAST) :
		ser_left; // RL14
	assign next_ser_quarter = launch ? acsc_pkg::QUARTER_ZERO :
		~running ? ser_quarter :
		quarter_end ? acsc_pkg::QUARTER_ZERO :
		3'(ser_quarter + acsc_pkg::QUARTER_STEP);
	assign next_ser_phase = launch ? acsc_pkg::PHASE_SETUP :
		(running & quarter_end) ? 2'(ser_phase + acsc_pkg::PHASE_STEP) :
		ser_phase;
	assign next_ser_shift = launch ? result_word :
		bit_end ? {ser_shift[acsc_pkg::WORD_MSB - 1:0], 1'b0} :
		ser_shift; // RL13
	assign next_int_data = launch ? result_word[acsc_pkg::WORD_MSB] :
		~bit_end ? int_data :
		last_bit ? tag_level :
		ser_shift[acsc_pkg::WORD_MSB - 1]; // RL15 RL16

	// Clock is high only in the two middle quarters of a live bit, so it
	// returns low after the sixteenth bit and stays there.
	assign next_int_clk = (next_ser_left != acsc_pkg::BIT_COUNT_NONE)
		& ((next_ser_phase == acsc_pkg::PHASE_RISE)
		| (next_ser_phase == acsc_pkg::PHASE_HIGH)); // RL14 RL17

	// Reset leaves the data clock low and idle until the first launch.
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			ser_left <= acsc_pkg::BIT_COUNT_NONE;
			ser_quarter <= acsc_pkg::QUARTER_ZERO;
			ser_phase <= acsc_pkg::PHASE_SETUP;
		end else begin
			ser_left <= next_ser_left;
			ser_quarter <= next_ser_quarter;
			ser_phase <= next_ser_phase;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			ser_shift <= acsc_pkg::FORMAT_KEEP;
			int_data <= 1'b0;
			int_clk <= 1'b0;
		end else begin
			ser_shift <= next_ser_shift;
			int_data <= next_int_data;
			int_clk <= next_int_clk;
		end
	end

	// External clock mode: each read request flips a toggle that the
	// link-side shifter watches. A level is used rather than a pulse, so
	// that it survives any ratio between the two clocks.
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			read_toggle <= 1'b0;
		end else if (read_req) begin
			read_toggle <= ~read_toggle; // RL2 RL19
		end
	end

	// The word and the chain level are copied at the request and held
	// until the next one. The link side therefore always samples quiet
	// data, even when a conversion ends while the toggle is crossing, and
	// a read during conversion returns the previous result.
	// The copy has no reset, like the result word that it mirrors.
	// Limitation: requests closer together than about four link clock
	// periods may still reload the copy under a load in progress.
	always_ff @(posedge SYS_CLK) begin
		if (read_req) begin
			read_word <= result_word; // RL5
			read_tag <= chain; // RL16
		end
	end

	// The chain level of a read is the synchronised level at the request.
	acsc_link_shift u_link (
		.link_clk(SERIAL_BIT_CLOCK_IN),
		.sys_rst(SYS_RST),
		.load_toggle(read_toggle),
		.word(read_word),
		.chain_level(read_tag),
		.data(link_data)
	);

	// Pin drive: internal mode owns the data clock pin, external mode
	// only listens on it.
	assign SERIAL_BIT_CLOCK_OUT = int_clk;
	assign SERIAL_BIT_CLOCK_OE = ~clk_ext; // RL12
	assign SERIAL_DATA = clk_ext ? link_data : int_data;
	assign BUSY_N = busy_n;
	assign CORE_HOLD = core_hold;
	assign POWER_SAVE = power_down; // RL4
	// The core follows the input whenever no conversion runs.
	assign TRACKING = busy_n; // RL9

endmodule : acsc_ctrl

// File: testbench/acsc_ctrl_assertions.sv
/*
 Port assertions for acsc_ctrl: start, busy, power-down and data clock.
 Assumes it is bound to acsc_ctrl and sees only that module's ports.
*/
`timescale 1ns/10ps
module acsc_ctrl_checker (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	// Host pins
	input wire logic CS_N,
	input wire logic READ_CONVERT,
	input wire logic CLOCK_SOURCE_SELECT,
	input wire logic BUSY_N,
	input wire logic TRACKING,
	input wire logic POWER_SAVE,
	// Serial link and core
	input wire logic SERIAL_BIT_CLOCK_OUT,
	input wire logic SERIAL_BIT_CLOCK_OE,
	input wire logic SERIAL_DATA,
	input wire logic CORE_HOLD,
	input wire logic CORE_DONE
);
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);

	// Rising data clock edges since the last launch.
	logic [4:0] pulse_cnt;
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST || CORE_HOLD)
			pulse_cnt <= 5'h00;
		else if ($rose(SERIAL_BIT_CLOCK_OUT))
			pulse_cnt <= pulse_cnt + 5'h01;
	end

	hold_busy_a: assert property (CORE_HOLD |-> !BUSY_N ##1 !CORE_HOLD)
		else $error("busy not low at launch");
	busy_stays_a: assert property (
		!BUSY_N && !CORE_DONE |=> !BUSY_N)
		else $error("busy ended early");
	done_release_a: assert property (
		!BUSY_N && CORE_DONE |=> BUSY_N && TRACKING)
		else $error("busy not released after done");
	no_restart_a: assert property (
		!BUSY_N && !$past(BUSY_N) |-> !CORE_HOLD)
		else $error("launch while busy");
	power_refuse_a: assert property (
		POWER_SAVE && $past(POWER_SAVE) |-> !CORE_HOLD)
		else $error("launch in power-down");
	start_held_a: assert property (
		CORE_HOLD |-> !$past(CS_N, 12) && !$past(READ_CONVERT, 12))
		else $error("launch without held start");
	clock_source_a: assert property (
		$stable(CLOCK_SOURCE_SELECT)[*5] |->
		SERIAL_BIT_CLOCK_OE != CLOCK_SOURCE_SELECT)
		else $error("clock drive wrong for source");
	pulse_limit_a: assert property (
		$rose(SERIAL_BIT_CLOCK_OUT) |-> pulse_cnt < 5'h10)
		else $error("too many data clock pulses");
	clock_rest_a: assert property (
		pulse_cnt == 5'h10 && !SERIAL_BIT_CLOCK_OUT |=> !SERIAL_BIT_CLOCK_OUT)
		else $error("data clock moved after last bit");
	bit_steady_a: assert property (
		SERIAL_BIT_CLOCK_OE &&
		(SERIAL_BIT_CLOCK_OUT || $fell(SERIAL_BIT_CLOCK_OUT))
		|-> $stable(SERIAL_DATA))
		else $error("data moved while clock high");
endmodule : acsc_ctrl_checker

bind acsc_ctrl acsc_ctrl_checker acsc_ctrl_checker_i (
	.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CS_N(CS_N),
	.READ_CONVERT(READ_CONVERT), .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT),
	.BUSY_N(BUSY_N), .TRACKING(TRACKING), .POWER_SAVE(POWER_SAVE),
	.SERIAL_BIT_CLOCK_OUT(SERIAL_BIT_CLOCK_OUT),
	.SERIAL_BIT_CLOCK_OE(SERIAL_BIT_CLOCK_OE), .SERIAL_DATA(SERIAL_DATA),
	.CORE_HOLD(CORE_HOLD), .CORE_DONE(CORE_DONE)
);

// File: testbench/acsc_core_model.sv
/*
 Behavioural analog core: answers each hold pulse with a finished code.
 Assumes hold and the preset result come on the system clock.
*/
`timescale 1ns/10ps
module acsc_core_model #(
	parameter int CONVERT_CYCLES = 400
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Request and answer
	input wire logic hold,
	input wire logic [15:0] result_set,
	output logic done,
	output logic [15:0] code
);
	int count;
	always_ff @(posedge clk) begin
		if (rst) begin
			count <= 0;
			done <= 1'b0;
			code <= 16'h0000;
		end else begin
			done <= (count == 1);
			// The bus wanders outside the done cycle so stale use shows.
			code <= (count == 1) ? result_set : ~code;
			if (hold)
				count <= CONVERT_CYCLES;
			else if (count != 0)
				count <= count - 1;
		end
	end
endmodule : acsc_core_model

// File: testbench/testbench.sv
/*
 Self-checking bench for acsc_ctrl: host pin sequences with internal and
 external readout. Assumes acsc_core_model answers each hold pulse.
*/
`timescale 1ns/10ps
module testbench;
	logic clk, rst, cs_n, rc, pd, sel, fmt, chain, lclk;
	logic busy_n, sclk, oe, sdata, hold, done;
	logic pwr_save, tracking;
	logic [15:0] code, result_set;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;

	acsc_ctrl acsc_ctrl_i (
		.SYS_CLK(clk), .SYS_RST(rst), .CS_N(cs_n), .READ_CONVERT(rc),
		.POWER_DOWN_IN(pd), .CLOCK_SOURCE_SELECT(sel),
		.RESULT_FORMAT_SELECT(fmt), .CHAIN_IN(chain), .BUSY_N(busy_n),
		.SERIAL_BIT_CLOCK_IN(lclk), .SERIAL_BIT_CLOCK_OUT(sclk),
		.SERIAL_BIT_CLOCK_OE(oe), .SERIAL_DATA(sdata), .CORE_HOLD(hold),
		.CORE_DONE(done), .CORE_CODE(code), .POWER_SAVE(pwr_save),
		.TRACKING(tracking)
	);
	acsc_core_model acsc_core_model_i (
		.clk(clk), .rst(rst), .hold(hold), .result_set(result_set),
		.done(done), .code(code)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] want);
		tests_run++;
		if (seen !== want) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask : check

	task automatic wrap_up();
		if (mismatches == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	// The link clock runs only when pulsed: during reset, before frames and inside frames.
	task automatic link_pulse();
		lclk = 1'b1;
		#6;
		lclk = 1'b0;
		#6;
	endtask : link_pulse

	task automatic wait_busy(input logic level);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (busy_n !== level && n < 600);
		check("busy", 16'(busy_n), 16'(level));
		check("tracking", 16'(tracking), 16'(level));
	endtask : wait_busy

	task automatic collect(input logic [15:0] want, input logic lvl,
		input bit chk);
		logic [15:0] got;
		logic prev;
		int n;
		n = 0;
		got = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			do begin
				prev = sclk;
				@(negedge clk);
				n++;
			end while (!(sclk === 1'b1 && prev === 1'b0) && n < 400);
			got = {got[14:0], sdata};
		end
		repeat (16) @(negedge clk);
		check("clock rest", 16'(sclk), 16'h0000);
		if (chk) begin
			check("serial word", got, want);
			check("serial chain", 16'(sdata), 16'(lvl));
		end
	endtask : collect

	task automatic convert(input logic [15:0] c, input logic r_first,
		input logic [15:0] want, input logic lvl, input bit chk);
		@(posedge clk);
		result_set <= c;
		chain <= lvl;
		cs_n <= r_first;
		rc <= ~r_first;
		repeat (3) @(posedge clk);
		{cs_n, rc} <= 2'b00;
		wait_busy(1'b0);
		@(posedge clk);
		chain <= ~lvl;
		collect(want, lvl, chk);
		@(posedge clk);
		rc <= 1'b1;
		repeat (4) @(posedge clk);
		rc <= 1'b0;
		wait_busy(1'b1);
		repeat (20) @(negedge clk);
		check("busy idle", 16'(busy_n), 16'h0001);
		@(posedge clk);
		{cs_n, rc} <= 2'b11;
	endtask : convert

	task automatic ext_read(input logic [15:0] want, input logic lvl,
		input bit by_rc);
		logic [15:0] got;
		@(posedge clk);
		chain <= lvl;
		rc <= ~by_rc;
		repeat (3) @(posedge clk);
		cs_n <= 1'b0;
		repeat (2) @(posedge clk);
		rc <= 1'b1;
		repeat (10) @(posedge clk);
		chain <= ~lvl;
		check("clock drive", 16'(oe), 16'h0000);
		repeat (2) link_pulse();
		for (int i = 0; i < 16; i++) begin
			link_pulse();
			got = {got[14:0], sdata};
		end
		link_pulse();
		check("link word", got, want);
		check("link chain", 16'(sdata), 16'(lvl));
		check("busy short start", 16'(busy_n), 16'h0001);
		@(posedge clk);
		{cs_n, rc} <= 2'b11;
	endtask : ext_read

	initial begin
		rst = 1'b1;
		{cs_n, rc} = 2'b11;
		{pd, sel, fmt, chain, lclk} = 5'h00;
		result_set = 16'h0000;
		fork
			repeat (5) link_pulse();
		join_none
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		check("clock drive", 16'(oe), 16'h0001);
		check("power save", 16'(pwr_save), 16'h0000);
		convert(16'hffff, 1'b1, 16'h0000, 1'b1, 1'b0);
		fmt <= 1'b1;
		convert(16'h0000, 1'b0, 16'h7fff, 1'b0, 1'b1);
		pd <= 1'b1;
		repeat (5) @(posedge clk);
		rc <= 1'b0;
		repeat (3) @(posedge clk);
		cs_n <= 1'b0;
		repeat (30) @(negedge clk);
		check("busy in power-down", 16'(busy_n), 16'h0001);
		check("power save", 16'(pwr_save), 16'h0001);
		@(posedge clk);
		{cs_n, rc} <= 2'b11;
		pd <= 1'b0;
		repeat (5) @(posedge clk);
		convert(16'h5a3c, 1'b1, 16'h0000, 1'b1, 1'b1);
		sel <= 1'b1;
		repeat (5) @(posedge clk);
		// The link reset is re-timed by the link clock, so let it run out.
		repeat (3) link_pulse();
		ext_read(16'h5a3c, 1'b0, 1'b0);
		ext_read(16'h5a3c, 1'b1, 1'b1);
		wrap_up();
	end
endmodule : testbench
